// ==== dv/ctx_tlb_props.sv ====
// ctx_tlb_props: port-level checks of the sync, control and miss logic.
// assumes: bound into ctx_tlb_sync_xlat_ctrl; ce goes low only around writes.
`timescale 1ns/1ns
module ctx_tlb_props (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // miss decision and configuration
   input wire logic miss_valid,
   input wire logic walk_start,
   input wire logic walk_fault,
   input wire logic walk_nonsecure,
   input wire logic asid_from_base1,
   input wire logic [2:0] region0_size_offset,
   input wire logic ext_addr_eff
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // -----------------------------------------------------------------
   // steps of a register read
   // -----------------------------------------------------------------
   sequence rd_at(logic [7:0] a);
      hsel && htrans[1] && hready && !hwrite && haddr[7:0] == a;
   endsequence
   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   a_bus_always_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_status_upper_zero: assert property (rd_at(8'h00) |=> hrdata[31:1] == 31'h0)
      else $error("status reserved bits not zero");
   a_trigger_reads_zero: assert property (rd_at(8'h04) |=> hrdata == 32'h0)
      else $error("trigger register read not zero");
   a_short_reserved_zero: assert property (rd_at(8'h08) ##0 !ext_addr_eff |=>
      (hrdata & ~ctx_tlb_pkg::SHORT_KEEP_MASK) == 32'h0)
      else $error("short layout reserved bits not zero");
   a_size_offset_match: assert property (rd_at(8'h08) |=> hrdata[2:0] == $past(region0_size_offset))
      else $error("size offset port differs from register");
   a_miss_one_answer: assert property (miss_valid |=> walk_start != walk_fault)
      else $error("miss answer missing or doubled");
   a_no_spurious_walk: assert property (!miss_valid |=> !walk_start && !walk_fault)
      else $error("walk answer without a miss");
   a_attrs_held: assert property (!miss_valid |=> $stable(walk_nonsecure) && $stable(asid_from_base1))
      else $error("walk attributes changed without a miss");
endmodule : ctx_tlb_props

bind ctx_tlb_sync_xlat_ctrl ctx_tlb_props u_ctx_tlb_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .miss_valid(miss_valid), .walk_start(walk_start), .walk_fault(walk_fault),
   .walk_nonsecure(walk_nonsecure), .asid_from_base1(asid_from_base1),
   .region0_size_offset(region0_size_offset), .ext_addr_eff(ext_addr_eff));

// ==== dv/ctx_tlb_sync_xlat_ctrl_bench.sv ====
// ctx_tlb_sync_xlat_ctrl_bench: directed self-checking bench for the slice.
// assumes: the design compiled with its package; the bench is the bus master.
`timescale 1ns/1ns
module ctx_tlb_sync_xlat_ctrl_bench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0;
   logic inval_accept = 1'b0;
   logic inval_done = 1'b0;
   logic miss_valid = 1'b0;
   logic miss_use_base1 = 1'b0;
   logic [31:0] hrdata;
   logic [2:0] region0_size_offset;
   logic hreadyout, hresp, inval_room, walk_start, walk_fault, walk_nonsecure, asid_from_base1, ext_addr_eff, irq;
   logic [31:0] rd_val;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;

   // free-running clock at 100 MHz
   always #5 hclk = ~hclk;

   // the single slave's ready is the bus ready
   ctx_tlb_sync_xlat_ctrl u_ctx_tlb_sync_xlat_ctrl (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .inval_accept(inval_accept),
      .inval_done(inval_done), .inval_room(inval_room), .miss_valid(miss_valid),
      .miss_use_base1(miss_use_base1), .walk_start(walk_start), .walk_fault(walk_fault),
      .walk_nonsecure(walk_nonsecure), .asid_from_base1(asid_from_base1),
      .region0_size_offset(region0_size_offset), .ext_addr_eff(ext_addr_eff), .irq(irq));

   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk

   // one single word transfer; read data lands in rd_val
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd_val = hrdata;
      // a write commits on this edge, so checks wait for it to settle
      @(negedge hclk);
   endtask : bus

   task inv(input logic acc, input logic dn);
      @(posedge hclk);
      inval_accept <= acc;
      inval_done <= dn;
      @(posedge hclk);
      inval_accept <= 1'b0;
      inval_done <= 1'b0;
   endtask : inv

   // answer is a one-cycle pulse in the cycle after the miss
   task miss(input logic b1, input logic ef, input logic st);
      @(posedge hclk);
      miss_valid <= 1'b1;
      miss_use_base1 <= b1;
      @(posedge hclk);
      miss_valid <= 1'b0;
      @(negedge hclk);
      chk({30'h0, walk_fault, walk_start}, {30'h0, ef, st}, "walk decision");
   endtask : miss

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task t_reset_regs;
      chk({27'h0, irq, walk_start, walk_fault, ext_addr_eff, inval_room}, 32'h1, "reset outputs");
      bus(1'b0, 8'h00, 32'h0);
      chk(rd_val, 32'h0, "status reset");
      bus(1'b1, 8'h00, 32'hffff_ffff);
      bus(1'b0, 8'h00, 32'h0);
      chk(rd_val, 32'h0, "status written");
      bus(1'b0, 8'h04, 32'h0);
      chk(rd_val, 32'h0, "trigger read");
      bus(1'b0, 8'h40, 32'h0);
      chk(rd_val, 32'h0, "unmapped read");
   endtask : t_reset_regs

   task t_xlat;
      bus(1'b1, 8'h08, 32'hffff_ffff);
      bus(1'b0, 8'h08, 32'h0);
      chk(rd_val, 32'hc000_4037, "short layout mask");
      chk({29'h0, region0_size_offset}, 32'h7, "size offset");
      chk({31'h0, ext_addr_eff}, 32'h1, "long selected");
      bus(1'b1, 8'h08, 32'h0000_003d);
      bus(1'b0, 8'h08, 32'h0);
      chk(rd_val, 32'h0000_0035, "bit 3 kept zero");
      chk({29'h0, region0_size_offset}, 32'h5, "size offset");
      chk({31'h0, ext_addr_eff}, 32'h0, "short selected");
      // wide, hypervisor, stage 2 force the long layout; secure does not
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 8'h0c, 32'h1 << i);
         chk({31'h0, ext_addr_eff}, {31'h0, i != 3}, "effective extended enable");
      end
   endtask : t_xlat

   task t_miss;
      bus(1'b1, 8'h0c, 32'h8);
      bus(1'b1, 8'h08, 32'h4000_0020);
      miss(1'b1, 1'b1, 1'b0);
      miss(1'b0, 1'b0, 1'b1);
      bus(1'b1, 8'h08, 32'h4000_0010);
      miss(1'b0, 1'b1, 1'b0);
      miss(1'b1, 1'b0, 1'b1);
      chk({31'h0, walk_nonsecure}, 32'h1, "secure bank base 1 attr");
      miss(1'b0, 1'b1, 1'b0);
      chk({31'h0, walk_nonsecure}, 32'h0, "base 0 attr clear");
      bus(1'b1, 8'h0c, 32'h0);
      miss(1'b1, 1'b0, 1'b1);
      chk({31'h0, walk_nonsecure}, 32'h0, "attr ignored outside secure");
      // stage 2 forces the long layout, where the disable bits move
      bus(1'b1, 8'h0c, 32'h4);
      bus(1'b1, 8'h08, 32'h00c0_0080);
      miss(1'b1, 1'b1, 1'b0);
      chk({31'h0, asid_from_base1}, 32'h1, "asid from base 1");
      miss(1'b0, 1'b1, 1'b0);
      bus(1'b1, 8'h08, 32'h0);
      miss(1'b1, 1'b0, 1'b1);
      chk({31'h0, asid_from_base1}, 32'h0, "asid from base 0");
      bus(1'b1, 8'h0c, 32'h0);
   endtask : t_miss

   task t_sync;
      bus(1'b1, 8'h10, 32'h3);
      inv(1'b1, 1'b0);
      inv(1'b1, 1'b0);
      bus(1'b1, 8'h04, 32'h0);
      bus(1'b0, 8'h00, 32'h0);
      chk(rd_val, 32'h1, "sync active");
      // a later invalidate must not hold the sync open
      inv(1'b1, 1'b0);
      inv(1'b0, 1'b1);
      bus(1'b0, 8'h00, 32'h0);
      chk(rd_val, 32'h1, "one still owed");
      inv(1'b0, 1'b1);
      bus(1'b0, 8'h00, 32'h0);
      chk(rd_val, 32'h0, "sync drained");
      chk({31'h0, irq}, 32'h0, "masked interrupt");
      bus(1'b0, 8'h10, 32'h0);
      chk(rd_val, 32'h1, "sync done sticky");
      bus(1'b1, 8'h14, 32'h1);
      chk({31'h0, irq}, 32'h1, "unmasked interrupt");
      bus(1'b1, 8'h10, 32'h1);
      chk({31'h0, irq}, 32'h0, "cleared interrupt");
      // software side: poll the active bit until it drops
      bus(1'b1, 8'h04, 32'h0);
      inv(1'b0, 1'b1);
      do begin
         bus(1'b0, 8'h00, 32'h0);
      end while (rd_val[0] !== 1'b0);
      chk(rd_val, 32'h0, "poll drained");
   endtask : t_sync

   // frozen clock enable: a write must leave no trace
   task t_freeze;
      @(posedge hclk);
      ce <= 1'b0;
      bus(1'b1, 8'h08, 32'h0000_0005);
      @(posedge hclk);
      ce <= 1'b1;
      bus(1'b0, 8'h08, 32'h0);
      chk(rd_val, 32'h0, "write lost while frozen");
   endtask : t_freeze

   // -----------------------------------------------------------------
   // main sequence and hang guard
   // -----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset_regs;
      t_xlat;
      t_miss;
      t_freeze;
      t_sync;
      stop_test;
   end

   // the whole run needs well under a thousand cycles
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_count++;
         stop_test;
      end
   end
endmodule : ctx_tlb_sync_xlat_ctrl_bench

// ==== logic/ctx_tlb_pkg.sv ====
// ctx_tlb_pkg: register offsets, field positions and reset values of one
// context bank's sync and translation control slice.
// assumes: a 32-bit AHB-Lite register bus with word-aligned registers.
package ctx_tlb_pkg;
   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_SYNC_STATUS = 8'h00;
   localparam logic [7:0] OFS_SYNC_TRIGGER = 8'h04;
   localparam logic [7:0] OFS_XLAT_CTRL = 8'h08;
   localparam logic [7:0] OFS_BANK_CFG = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam int ADDR_BITS = 8;

   // -----------------------------------------------------------------
   // translation control field positions
   // -----------------------------------------------------------------
   localparam int BIT_EXT_ADDR_EN = 31;
   localparam int BIT_WALK1_NS = 30;
   localparam int BIT_WALK1_DIS_LONG = 23;
   localparam int BIT_ASID_SEL = 22;
   localparam int BIT_WALK0_NS = 14;
   localparam int BIT_WALK0_DIS_LONG = 7;
   localparam int BIT_WALK1_DIS_SHORT = 5;
   localparam int BIT_WALK0_DIS_SHORT = 4;
   localparam int SIZE0_MSB = 2;
   // bits that hold storage in the short layout; others read zero
   localparam logic [31:0] SHORT_KEEP_MASK = 32'hc000_4037;
   localparam logic [31:0] LONG_KEEP_MASK = 32'hffff_fff7;

   // -----------------------------------------------------------------
   // bank configuration bits, interrupt bits, reset values
   // -----------------------------------------------------------------
   localparam int CFG_WIDE = 0;
   localparam int CFG_HYP = 1;
   localparam int CFG_STAGE2 = 2;
   localparam int CFG_SECURE = 3;
   localparam int IRQ_SYNC_DONE = 0;
   localparam int IRQ_WALK_FAULT = 1;
   localparam int IRQ_BITS = 2;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [31:0] XLAT_RESET = 32'h0000_0000;
   localparam logic [3:0] CFG_RESET = 4'h0;
   localparam int INVAL_CNT_W = 4;
endpackage : ctx_tlb_pkg

// ==== logic/ctx_tlb_sync_xlat_ctrl.sv ====
// ctx_tlb_sync_xlat_ctrl: one context bank's TLB sync trigger and status,
// its translation control register and the miss-time walk decision, as an
// AHB-Lite slave with a sticky interrupt status and mask.
// assumes: single clock; the TLB raises invalidate accept/done pulses and
// presents one miss at a time with its region already chosen.
//
// Summary of operation
// - sync status is 32-bit, read-only, resets zero.
// - active bit reads 0 once prior invalidates finish.
// - active bit reads 1 while prior invalidates pending.
// - writing sync trigger starts a synchronisation.
// - sync waits for invalidates accepted before it.
// - trigger register write-only, reads zero.
// - translation control is 32-bit read-write, reset undefined.
// - layout chosen by wide mode and extended enable.
// - extended enable forced by stage2, wide, hypervisor.
// - bit 31 selects short or long descriptors.
// - bits 30/14 non-secure walk attributes, secure only.
// - short bit 5 disables base 1 walks.
// - short bit 4 disables base 0 walks.
// - bits 2:0 hold region 0 size offset.
// - control settings pick table base on miss.
// - long-layout disable bits fault without walking.
// - long-layout bit 22 selects asid source.
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
module ctx_tlb_sync_xlat_ctrl #(
   parameter int CNT_W = ctx_tlb_pkg::INVAL_CNT_W
) (
   // clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // invalidate traffic from the tlb
   input wire logic inval_accept,
   input wire logic inval_done,
   output logic inval_room,
   // tlb miss decision
   input wire logic miss_valid,
   input wire logic miss_use_base1,
   output logic walk_start,
   output logic walk_fault,
   output logic walk_nonsecure,
   output logic asid_from_base1,
   output logic [2:0] region0_size_offset,
   output logic ext_addr_eff,
   // interrupt
   output logic irq
);
   initial begin
      if (CNT_W < 1 || CNT_W > 16) $error("ctx_tlb_sync_xlat_ctrl: CNT_W out of range");
   end

   // -----------------------------------------------------------------
   // bus address phase capture
   // -----------------------------------------------------------------
   logic wr_pend_reg, wr_pend_next;
   logic [ctx_tlb_pkg::ADDR_BITS-1:0] wr_addr_reg, wr_addr_next;
   logic [31:0] rdata_reg, rdata_next;
   logic take;
   logic [ctx_tlb_pkg::ADDR_BITS-1:0] a_ofs;

   // only nonseq/seq transfers to this slave while the bus is ready
   assign take = hsel & htrans[1] & hready;
   assign a_ofs = haddr[ctx_tlb_pkg::ADDR_BITS-1:0];

   // -----------------------------------------------------------------
   // register state
   // -----------------------------------------------------------------
   logic [31:0] xlat_reg, xlat_next;
   logic [3:0] cfg_reg, cfg_next;
   logic [ctx_tlb_pkg::IRQ_BITS-1:0] ists_reg, ists_next;
   logic [ctx_tlb_pkg::IRQ_BITS-1:0] imask_reg, imask_next;
   logic walk_start_reg, walk_start_next;
   logic walk_fault_reg, walk_fault_next;
   logic walk_ns_reg, walk_ns_next;
   logic asid1_reg, asid1_next;
   logic sync_start, sync_active, sync_done;
   logic dec_fault, dec_ns, dec_asid1;
   logic wr_now;
   logic [31:0] keep_mask;
   logic [ctx_tlb_pkg::IRQ_BITS-1:0] ev;

   assign wr_now = wr_pend_reg;

   // effective extended enable from stored bit and bank attributes
   assign ext_addr_eff = xlat_reg[ctx_tlb_pkg::BIT_EXT_ADDR_EN]
      | cfg_reg[ctx_tlb_pkg::CFG_STAGE2] | cfg_reg[ctx_tlb_pkg::CFG_WIDE]
      | cfg_reg[ctx_tlb_pkg::CFG_HYP];

   // layout in force decides which bits hold storage
   assign keep_mask = (ext_addr_eff || cfg_reg[ctx_tlb_pkg::CFG_WIDE])
      ? ctx_tlb_pkg::LONG_KEEP_MASK : ctx_tlb_pkg::SHORT_KEEP_MASK;

   // a write to the trigger in its data phase starts a sync
   assign sync_start = wr_now && wr_addr_reg == ctx_tlb_pkg::OFS_SYNC_TRIGGER;

   // -----------------------------------------------------------------
   // sub-blocks
   // -----------------------------------------------------------------
   inval_tracker #(.CNT_W(CNT_W)) u_track (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .inval_accept(inval_accept),
      .inval_done(inval_done),
      .sync_start(sync_start),
      .sync_active(sync_active),
      .sync_done(sync_done),
      .inval_room(inval_room)
   );

   walk_select u_walk (
      .xlat_ctrl(xlat_reg),
      .ext_addr_eff(ext_addr_eff),
      .secure_bank(cfg_reg[ctx_tlb_pkg::CFG_SECURE]),
      .use_base1(miss_use_base1),
      .walk_fault(dec_fault),
      .walk_nonsecure(dec_ns),
      .asid_from_base1(dec_asid1)
   );

   // -----------------------------------------------------------------
   // bus and register next state
   // -----------------------------------------------------------------
   // writes are committed in the data phase when hwdata is valid;
   // a read is answered from a word captured at the address phase,
   // so a read right after a write sees the old value for one access
   always_comb begin
      wr_pend_next = take & hwrite;
      wr_addr_next = take ? a_ofs : wr_addr_reg;
      rdata_next = rdata_reg;
      xlat_next = xlat_reg;
      cfg_next = cfg_reg;
      imask_next = imask_reg;
      ev = '0;
      ev[ctx_tlb_pkg::IRQ_SYNC_DONE] = sync_done;
      ev[ctx_tlb_pkg::IRQ_WALK_FAULT] = miss_valid & dec_fault;
      ists_next = ists_reg;
      if (wr_now) begin
         unique case (wr_addr_reg)
            ctx_tlb_pkg::OFS_XLAT_CTRL: xlat_next = hwdata & keep_mask;
            ctx_tlb_pkg::OFS_BANK_CFG: cfg_next = hwdata[3:0];
            ctx_tlb_pkg::OFS_IRQ_STATUS: ists_next = ists_reg & ~hwdata[ctx_tlb_pkg::IRQ_BITS-1:0];
            ctx_tlb_pkg::OFS_IRQ_MASK: imask_next = hwdata[ctx_tlb_pkg::IRQ_BITS-1:0];
            default: ; // status and trigger ignore data; unmapped ignored
         endcase
      end
      // a new event wins over a clear in the same cycle
      ists_next = ists_next | ev;
      if (take && !hwrite) begin
         unique case (a_ofs)
            ctx_tlb_pkg::OFS_SYNC_STATUS: rdata_next = ctx_tlb_pkg::STATUS_RESET | {31'h0, sync_active};
            ctx_tlb_pkg::OFS_XLAT_CTRL: rdata_next = xlat_reg & keep_mask;
            ctx_tlb_pkg::OFS_BANK_CFG: rdata_next = {28'h0, cfg_reg};
            ctx_tlb_pkg::OFS_IRQ_STATUS: rdata_next = {30'h0, ists_reg};
            ctx_tlb_pkg::OFS_IRQ_MASK: rdata_next = {30'h0, imask_reg};
            default: rdata_next = 32'h0000_0000; // trigger and unmapped read zero
         endcase
      end
   end

   // -----------------------------------------------------------------
   // walk decision registers
   // -----------------------------------------------------------------
   // each miss yields one registered pulse of start or fault
   always_comb begin
      walk_start_next = miss_valid & ~dec_fault;
      walk_fault_next = miss_valid & dec_fault;
      walk_ns_next = miss_valid ? dec_ns : walk_ns_reg;
      asid1_next = miss_valid ? dec_asid1 : asid1_reg;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         rdata_reg <= 32'h0000_0000;
         xlat_reg <= ctx_tlb_pkg::XLAT_RESET; // value not promised to software
         cfg_reg <= ctx_tlb_pkg::CFG_RESET;
         ists_reg <= '0;
         imask_reg <= '0;
         walk_start_reg <= 1'b0;
         walk_fault_reg <= 1'b0;
         walk_ns_reg <= 1'b0;
         asid1_reg <= 1'b0;
      end else if (ce) begin
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         rdata_reg <= rdata_next;
         xlat_reg <= xlat_next;
         cfg_reg <= cfg_next;
         ists_reg <= ists_next;
         imask_reg <= imask_next;
         walk_start_reg <= walk_start_next;
         walk_fault_reg <= walk_fault_next;
         walk_ns_reg <= walk_ns_next;
         asid1_reg <= asid1_next;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // zero wait states; every access is answered okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;
   assign walk_start = walk_start_reg;
   assign walk_fault = walk_fault_reg;
   assign walk_nonsecure = walk_ns_reg;
   assign asid_from_base1 = asid1_reg;
   assign region0_size_offset = xlat_reg[ctx_tlb_pkg::SIZE0_MSB:0];
   assign irq = |(ists_reg & imask_reg);
endmodule : ctx_tlb_sync_xlat_ctrl

// ==== logic/inval_tracker.sv ====
// inval_tracker: counts invalidates accepted before a sync and reports the
// sync active until that snapshot of outstanding work has drained.
// assumes: invalidate accept and done pulses are synchronous to hclk.
`timescale 1ns/1ns
module inval_tracker #(
   parameter int CNT_W = ctx_tlb_pkg::INVAL_CNT_W
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // invalidate traffic
   input wire logic inval_accept,
   input wire logic inval_done,
   input wire logic sync_start,
   // result
   output logic sync_active,
   output logic sync_done,
   output logic inval_room
);
   initial begin
      if (CNT_W < 1 || CNT_W > 16) $error("inval_tracker: CNT_W out of range");
   end

   logic [CNT_W-1:0] outst_reg, outst_next;
   logic [CNT_W-1:0] owed_reg, owed_next;
   logic active_reg, active_next;
   logic done_reg, done_next;

   // outstanding count and the share of it owed to the current sync
   always_comb begin
      outst_next = outst_reg;
      owed_next = owed_reg;
      active_next = active_reg;
      done_next = 1'b0;
      if (inval_accept && !inval_done) outst_next = outst_reg + CNT_W'(1);
      if (inval_done && !inval_accept && outst_reg != '0) outst_next = outst_reg - CNT_W'(1);
      if (inval_done && owed_reg != '0) owed_next = owed_reg - CNT_W'(1);
      if (sync_start) begin
         // an accept in this same cycle follows the sync, not precedes it
         owed_next = (inval_done && outst_reg != '0) ? outst_reg - CNT_W'(1) : outst_reg;
         active_next = 1'b1;
      end else if (active_reg && owed_next == '0) begin
         active_next = 1'b0;
         done_next = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         outst_reg <= '0;
         owed_reg <= '0;
         active_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (ce) begin
         outst_reg <= outst_next;
         owed_reg <= owed_next;
         active_reg <= active_next;
         done_reg <= done_next;
      end
   end

   assign sync_active = active_reg;
   assign sync_done = done_reg;
   assign inval_room = (outst_reg != {CNT_W{1'b1}}); // back-pressure when counter full
endmodule : inval_tracker

// ==== logic/walk_select.sv ====
// walk_select: decodes the effective translation control for a TLB miss:
// which table base supplies the asid, whether the walk is disabled, walk attributes.
// assumes: control word and bank config are stable registered values.
`timescale 1ns/1ns
module walk_select (
   // configuration
   input wire logic [31:0] xlat_ctrl,
   input wire logic ext_addr_eff,
   input wire logic secure_bank,
   // miss request
   input wire logic use_base1,
   // decision
   output logic walk_fault,
   output logic walk_nonsecure,
   output logic asid_from_base1
);
   logic dis_short, dis_long, ns_raw;

   // pick the per-base disable bit for the active layout
   always_comb begin
      dis_short = use_base1 ? xlat_ctrl[ctx_tlb_pkg::BIT_WALK1_DIS_SHORT]
                            : xlat_ctrl[ctx_tlb_pkg::BIT_WALK0_DIS_SHORT];
      dis_long = use_base1 ? xlat_ctrl[ctx_tlb_pkg::BIT_WALK1_DIS_LONG]
                           : xlat_ctrl[ctx_tlb_pkg::BIT_WALK0_DIS_LONG];
      ns_raw = use_base1 ? xlat_ctrl[ctx_tlb_pkg::BIT_WALK1_NS] : xlat_ctrl[ctx_tlb_pkg::BIT_WALK0_NS];
      walk_fault = ext_addr_eff ? dis_long : dis_short;
      walk_nonsecure = secure_bank & ns_raw;
      // short layout has no asid select; base 0 supplies it
      asid_from_base1 = ext_addr_eff & xlat_ctrl[ctx_tlb_pkg::BIT_ASID_SEL];
   end
endmodule : walk_select
